// ===== gpio_pkg.sv
/*
 * Constants of the multipurpose pin control block: register offsets, field
 * positions, function codes, operating mode codes and reset values.
 * Assumes a 32-bit APB register port with one aligned word per register.
 */
package gpio_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL   = 8'h00;  // Function, lock, test bit, measure enable.
    localparam logic [7:0] OFF_PWM    = 8'h04;  // Duty and frequency select.
    localparam logic [7:0] OFF_TIMER  = 8'h08;  // Cyclic sense on-time setting.
    localparam logic [7:0] OFF_PULL   = 8'h0c;  // Wake pull structures.
    localparam logic [7:0] OFF_STATUS = 8'h10;  // Flags, write one to clear.
    // Control register fields.
    localparam int FUNC_LSB  = 0;               // Three-bit function code.
    localparam int LOCK_BIT  = 3;               // Configuration lock.
    localparam int TEST_BIT  = 4;               // Fail output test bit.
    localparam int MEAS_BIT  = 5;               // Voltage measure enable.
    // PWM register fields.
    localparam int FREQ_BIT  = 8;               // Frequency select above the duty field.
    // Status register fields.
    localparam int OL_BIT    = 0;               // Open load flag.
    localparam int OC_BIT    = 1;               // Overcurrent flag.
    localparam int WAKE_BIT  = 2;               // Pin wake event flag.
    localparam int FAIL_BIT  = 3;               // Failure flag.
    localparam int CMDF_BIT  = 4;               // Serial command failure flag.
    localparam int LVL_BIT   = 5;               // Pin level status, read only.
    // Function codes.
    localparam logic [2:0] FN_FO    = 3'h0;     // Fail output, default.
    localparam logic [2:0] FN_FOMAX = 3'h2;     // Highest fail output code.
    localparam logic [2:0] FN_CS    = 3'h3;     // High side with cyclic sense.
    localparam logic [2:0] FN_OFF   = 3'h4;     // Off.
    localparam logic [2:0] FN_WAKE  = 3'h5;     // Wake input.
    localparam logic [2:0] FN_LS    = 3'h6;     // Low side with PWM.
    localparam logic [2:0] FN_HS    = 3'h7;     // High side with PWM.
    // Operating modes presented by the mode controller.
    localparam logic [2:0] MD_NORMAL   = 3'h0;
    localparam logic [2:0] MD_STOP     = 3'h1;
    localparam logic [2:0] MD_SLEEP    = 3'h2;
    localparam logic [2:0] MD_RESTART  = 3'h3;
    localparam logic [2:0] MD_FAILSAFE = 3'h4;
    // Reset values.
    localparam logic [3:0] TIMER_RST = 4'h0;    // Timer stopped.
    localparam logic [1:0] PULL_RST  = 2'h0;    // No pull structure.
    localparam logic       REF_RST   = 1'b0;    // Stored wake reference is low.
endpackage : gpio_pkg

// ===== gpio_ctrl.sv
/*
 * Multipurpose high-voltage pin controller: function select, switch drive,
 * diagnosis flags, fail output, wake detection and measurement interlock.
 * Assumes filtered comparator inputs, an external PWM phase and timer on-time,
 * and a mode controller that presents the current operating mode.
 */
`timescale 1ns/1ns
module gpio_ctrl #(
    parameter int DUTY_W = 8                    // Width of the PWM duty setting.
) (
    input  wire logic              pclk,        // Bus and block clock.
    input  wire logic              presetn,     // Asynchronous reset, active low.
    input  wire logic              psel,        // APB select.
    input  wire logic              penable,     // APB access phase.
    input  wire logic              pwrite,      // APB direction.
    input  wire logic [7:0]        paddr,       // APB byte address.
    input  wire logic [31:0]       pwdata,      // APB write data.
    output logic [31:0]            prdata,      // APB read data.
    output logic                   pready,      // APB ready.
    output logic                   pslverr,     // APB error on unmapped address.
    input  wire logic [2:0]        sbc_mode,    // Current operating mode.
    input  wire logic              soft_reset,  // Soft reset command pulse.
    input  wire logic              failure_event, // Failure trigger pulse.
    input  wire logic              failure_present, // Failure condition level.
    input  wire logic              pwm_phase,   // PWM generator on phase.
    input  wire logic              timer_on,    // Cyclic sense on-time level.
    input  wire logic              timer_start, // Timer started through on-time.
    input  wire logic              oc_detect,   // Filtered overcurrent.
    input  wire logic              ol_detect,   // Filtered open load.
    input  wire logic              pin_level,   // Filtered pin level.
    input  wire logic              sleep_request, // Sleep entry request pulse.
    input  wire logic              wake_only_source, // Pin wake is the only source.
    output logic                   fail_output_pin_o, // Fail output drive level.
    output logic                   fail_output_pin_oe, // Fail output drive enable.
    output logic                   low_side_switch, // Low side switch gate.
    output logic                   high_side_switch, // High side switch gate.
    output logic [1:0]             wake_pull,   // Effective pull structures.
    output logic                   wake_request, // Qualified wake pulse.
    output logic                   learning_start, // Learning cycle start pulse.
    output logic                   restart_request, // Refused sleep, go to restart.
    output logic [DUTY_W-1:0]      pwm_duty,    // Duty setting to the generator.
    output logic                   pwm_frequency_select, // Frequency select.
    output logic [3:0]             timer_on_time // Timer on-time setting.
);
    if (DUTY_W < 2 || DUTY_W > 8) begin : g_duty_w_check
        $error("DUTY_W must be 2 to 8 so the duty field stays below the frequency bit.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // True for any fail output code.
    function automatic logic is_fo(input logic [2:0] c);
        is_fo = (c <= gpio_pkg::FN_FOMAX);
    endfunction : is_fo

    // True for any switch code, cyclic sense included.
    function automatic logic is_sw(input logic [2:0] c);
        is_sw = (c == gpio_pkg::FN_CS) || (c == gpio_pkg::FN_LS) || (c == gpio_pkg::FN_HS);
    endfunction : is_sw

    logic [2:0]        func;                    // Function code.
    logic              cfg_lock;                // Configuration lock.
    logic              test_bit;                // Fail output test bit.
    logic              meas;                    // Voltage measure enable.
    logic [1:0]        pull_reg;                // Stored pull setting.
    logic              ol_flag;                 // Open load flag.
    logic              oc_flag;                 // Overcurrent flag.
    logic              wake_flag;               // Pin wake event flag.
    logic              fail_flag;               // Failure flag.
    logic              cmd_fail;                // Serial command failure flag.
    logic              level_stat;              // Pin level status.
    logic              wake_ref;                // Last filtered wake level.
    logic              fo_latch;                // Failure-activated fail output.
    logic [2:0]        prev_mode;               // Mode one cycle ago.
    logic              wr;                      // Write access phase.
    logic [31:0]       clr;                     // Status bits software clears.
    logic              drive_ok;                // Switches allowed in this mode.
    logic              pwm_on;                  // Effective PWM on phase.
    logic              on_time;                 // Switch on-time for diagnosis.
    logic              oc_shut;                 // Overcurrent shutdown event.
    logic              mode_kill;               // Restart or fail-safe entry.
    logic              fn_wr;                   // Software function write request.
    logic              fn_ok;                   // Function write accepted.
    logic              meas_bad;                // Refused measure or function request.

    ////////////////////////////////////////////////////////////////////////////
    // APB slave decode; every access completes in its first access cycle.

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign clr     = (wr && paddr == gpio_pkg::OFF_STATUS) ? pwdata : 32'h0;
    assign pslverr = psel && penable && !(paddr == gpio_pkg::OFF_CTRL || paddr == gpio_pkg::OFF_PWM ||
                     paddr == gpio_pkg::OFF_TIMER || paddr == gpio_pkg::OFF_PULL ||
                     paddr == gpio_pkg::OFF_STATUS);

    // Read mux; the level status reads as zero outside Normal mode.
    always_comb begin
        prdata = 32'h0;
        case (paddr)
            gpio_pkg::OFF_CTRL: begin
                prdata[gpio_pkg::FUNC_LSB +: 3] = func;
                prdata[gpio_pkg::LOCK_BIT]      = cfg_lock;
                prdata[gpio_pkg::TEST_BIT]      = test_bit;
                prdata[gpio_pkg::MEAS_BIT]      = meas;
            end
            gpio_pkg::OFF_PWM: begin
                prdata[DUTY_W-1:0]              = pwm_duty;
                prdata[gpio_pkg::FREQ_BIT]      = pwm_frequency_select;
            end
            gpio_pkg::OFF_TIMER: prdata[3:0]    = timer_on_time;
            gpio_pkg::OFF_PULL:  prdata[1:0]    = pull_reg;
            gpio_pkg::OFF_STATUS: begin
                prdata[gpio_pkg::OL_BIT]        = ol_flag;
                prdata[gpio_pkg::OC_BIT]        = oc_flag;
                prdata[gpio_pkg::WAKE_BIT]      = wake_flag;
                prdata[gpio_pkg::FAIL_BIT]      = fail_flag;
                prdata[gpio_pkg::CMDF_BIT]      = cmd_fail;
                prdata[gpio_pkg::LVL_BIT]       = level_stat && sbc_mode == gpio_pkg::MD_NORMAL;
            end
            default: prdata = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode tracking and switch qualification.

    // Remembers the previous mode so entries can be seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_mode <= gpio_pkg::MD_NORMAL;
        end else begin
            prev_mode <= sbc_mode;
        end
    end

    assign mode_kill = (sbc_mode == gpio_pkg::MD_RESTART || sbc_mode == gpio_pkg::MD_FAILSAFE) &&
                       sbc_mode != prev_mode;
    // Switches run in Normal, Stop and Sleep; battery undervoltage is no term here.
    assign drive_ok  = (sbc_mode <= gpio_pkg::MD_SLEEP) && !meas;
    // Zero duty holds the switch off, full duty holds it on.
    assign pwm_on    = (pwm_duty == '0) ? 1'b0 : (&pwm_duty) ? 1'b1 : pwm_phase;
    assign low_side_switch  = drive_ok && func == gpio_pkg::FN_LS && pwm_on;
    // Only code 011 lets the timer drive the high side.
    assign high_side_switch = drive_ok && ((func == gpio_pkg::FN_HS && pwm_on) ||
                              (func == gpio_pkg::FN_CS && timer_on));
    // Diagnosis looks only at the on-time of an active switch.
    assign on_time   = low_side_switch || high_side_switch;
    assign oc_shut   = on_time && oc_detect;
    assign learning_start = timer_start && func == gpio_pkg::FN_CS;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register.

    // Function writes need Normal mode, no lock and no measurement.
    assign fn_wr    = wr && paddr == gpio_pkg::OFF_CTRL;
    assign fn_ok    = fn_wr && sbc_mode == gpio_pkg::MD_NORMAL && !cfg_lock && !meas;
    assign meas_bad = fn_wr && ((meas && (pwdata[gpio_pkg::FUNC_LSB +: 3] != func ||
                      pwdata[gpio_pkg::TEST_BIT])) ||
                      (!meas && pwdata[gpio_pkg::MEAS_BIT] && is_fo(func)));

    // Function code: forced shutdown wins over a write and over soft reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func <= gpio_pkg::FN_FO;
        end else if (is_sw(func) && (oc_shut || mode_kill)) begin
            func <= gpio_pkg::FN_OFF;
        end else if (soft_reset && !cfg_lock) begin
            func <= gpio_pkg::FN_FO;
        end else if (fn_ok) begin
            func <= pwdata[gpio_pkg::FUNC_LSB +: 3];
        end
    end

    // Lock, test bit and measure enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_lock <= 1'b0;
            test_bit <= 1'b0;
            meas     <= 1'b0;
        end else begin
            if (fn_wr) begin
                cfg_lock <= pwdata[gpio_pkg::LOCK_BIT];
            end
            if (sbc_mode == gpio_pkg::MD_RESTART && mode_kill) begin
                test_bit <= 1'b0;
            end else if (fn_wr && !meas) begin
                test_bit <= pwdata[gpio_pkg::TEST_BIT];
            end
            if (fn_wr && !(pwdata[gpio_pkg::MEAS_BIT] && is_fo(func))) begin
                meas <= pwdata[gpio_pkg::MEAS_BIT];
            end
        end
    end

    // Timer, PWM and pull settings; soft reset restores timer and PWM.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_duty             <= '0;
            pwm_frequency_select <= 1'b0;
            timer_on_time        <= gpio_pkg::TIMER_RST;
            pull_reg             <= gpio_pkg::PULL_RST;
        end else if (soft_reset) begin
            pwm_duty             <= '0;
            pwm_frequency_select <= 1'b0;
            timer_on_time        <= gpio_pkg::TIMER_RST;
        end else if (wr) begin
            if (paddr == gpio_pkg::OFF_PWM) begin
                pwm_duty             <= pwdata[DUTY_W-1:0];
                pwm_frequency_select <= pwdata[gpio_pkg::FREQ_BIT];
            end
            if (paddr == gpio_pkg::OFF_TIMER) begin
                timer_on_time <= pwdata[3:0];
            end
            if (paddr == gpio_pkg::OFF_PULL) begin
                pull_reg <= pwdata[1:0];
            end
        end
    end

    // Pulls are released while measuring.
    assign wake_pull = meas ? 2'b00 : pull_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Diagnosis and command flags; a set in the clear cycle wins.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ol_flag  <= 1'b0;
            oc_flag  <= 1'b0;
            cmd_fail <= 1'b0;
        end else begin
            ol_flag  <= (func == gpio_pkg::FN_HS && high_side_switch && ol_detect) ||
                        (ol_flag && !clr[gpio_pkg::OL_BIT]);
            oc_flag  <= oc_shut || (oc_flag && !clr[gpio_pkg::OC_BIT]);
            cmd_fail <= meas_bad || (cmd_fail && !clr[gpio_pkg::CMDF_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Failure flag and fail output.

    // Failure is always recorded; a refused sleep also records it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_flag <= 1'b0;
            fo_latch  <= 1'b0;
        end else begin
            fail_flag <= failure_event || restart_request || failure_present ||
                         (fail_flag && !clr[gpio_pkg::FAIL_BIT]);
            if (failure_event && is_fo(func) && !meas) begin
                fo_latch <= 1'b1;
            end else if (!fail_flag) begin
                fo_latch <= 1'b0;
            end
        end
    end

    // Open-drain fail output pulls low only in fail output function.
    assign fail_output_pin_o  = 1'b0;
    assign fail_output_pin_oe = is_fo(func) && !meas && (fo_latch || test_bit);

    ////////////////////////////////////////////////////////////////////////////
    // Wake detection and level status.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_ref   <= gpio_pkg::REF_RST;
            wake_flag  <= 1'b0;
            level_stat <= 1'b0;
        end else begin
            if (func == gpio_pkg::FN_WAKE && !meas) begin
                wake_ref <= pin_level;
            end
            if (wake_request) begin
                wake_flag <= 1'b1;
            end else if (mode_kill && sbc_mode == gpio_pkg::MD_FAILSAFE) begin
                wake_flag <= 1'b0;
            end else if (clr[gpio_pkg::WAKE_BIT]) begin
                wake_flag <= 1'b0;
            end
            if (!meas && func != gpio_pkg::FN_CS && func != gpio_pkg::FN_OFF && !is_fo(func)) begin
                level_stat <= pin_level;
            end
        end
    end

    // Any difference from the last filtered level is a wake event in any mode.
    assign wake_request    = func == gpio_pkg::FN_WAKE && !meas && pin_level != wake_ref;
    assign restart_request = sleep_request && meas && wake_only_source;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_oc_off;
        @(posedge pclk) disable iff (!presetn)
        oc_shut |=> func == gpio_pkg::FN_OFF && !low_side_switch && !high_side_switch;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("Overcurrent did not force Off.");

    property p_kill;
        @(posedge pclk) disable iff (!presetn)
        mode_kill && is_sw(func) |=> func == gpio_pkg::FN_OFF;
    endproperty
    a_kill: assert property (p_kill) else $error("Mode entry did not force Off.");

    sequence s_lock_write;
        fn_wr && cfg_lock && !is_sw(func) && !soft_reset;
    endsequence
    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        s_lock_write |=> $stable(func);
    endproperty
    a_lock: assert property (p_lock) else $error("Locked function changed.");

    property p_duty;
        @(posedge pclk) disable iff (!presetn)
        pwm_duty == '0 |-> !high_side_switch || func == gpio_pkg::FN_CS;
    endproperty
    a_duty: assert property (p_duty) else $error("Switch on at zero duty.");

    property p_meas_pull;
        @(posedge pclk) disable iff (!presetn)
        meas |-> wake_pull == 2'b00 && !wake_request && !fail_output_pin_oe;
    endproperty
    a_meas_pull: assert property (p_meas_pull) else $error("Measurement left pin active.");

    property p_meas_refuse;
        @(posedge pclk) disable iff (!presetn)
        fn_wr && !meas && pwdata[gpio_pkg::MEAS_BIT] && is_fo(func) |=> !meas && cmd_fail;
    endproperty
    a_meas_refuse: assert property (p_meas_refuse) else $error("Measurement not refused.");

    property p_nofo;
        @(posedge pclk) disable iff (!presetn)
        !is_fo(func) |-> !fail_output_pin_oe;
    endproperty
    a_nofo: assert property (p_nofo) else $error("Fail output active outside its function.");

    sequence s_sleep_bad;
        sleep_request && meas && wake_only_source;
    endsequence
    property p_sleep;
        @(posedge pclk) disable iff (!presetn)
        s_sleep_bad |-> restart_request ##1 fail_flag;
    endproperty
    a_sleep: assert property (p_sleep) else $error("Refused sleep not flagged.");

endmodule : gpio_ctrl

// ===== failout_gpio_switch_control_tb_top.sv
/* Self-checking bench for the multipurpose pin controller.
   Assumes the gpio_pkg constants and a zero-wait APB slave. */
`timescale 1ns/1ns
module failout_gpio_switch_control_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, soft_reset, failure_event, failure_present;
    logic pwm_phase, timer_on, timer_start, oc_detect, ol_detect, pin_level, sleep_request, wake_only_source;
    logic fo_o, fo_oe, ls, hs, wake_request, learning_start, restart_request, freq, rerr;
    logic [7:0]  paddr, pwm_duty;
    logic [31:0] pwdata, prdata, rdv;
    logic [2:0]  sbc_mode;
    logic [1:0]  wake_pull;
    logic [3:0]  timer_on_time;
    int num_errors = 0, checks_done = 0, cycles = 0;
    gpio_ctrl u_gpio_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sbc_mode(sbc_mode),
        .soft_reset(soft_reset), .failure_event(failure_event), .failure_present(failure_present),
        .pwm_phase(pwm_phase), .timer_on(timer_on), .timer_start(timer_start), .oc_detect(oc_detect),
        .ol_detect(ol_detect), .pin_level(pin_level), .sleep_request(sleep_request),
        .wake_only_source(wake_only_source), .fail_output_pin_o(fo_o), .fail_output_pin_oe(fo_oe),
        .low_side_switch(ls), .high_side_switch(hs), .wake_pull(wake_pull), .wake_request(wake_request),
        .learning_start(learning_start), .restart_request(restart_request), .pwm_duty(pwm_duty),
        .pwm_frequency_select(freq), .timer_on_time(timer_on_time));
    ////////////////////////////////////////////////////////////////
    // Clock and a hang limit well above the expected run length.
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One APB transfer; held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
        #1;
    endtask : apb
    task automatic w(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask : w
    task automatic rd(input logic [7:0] a); apb(0, a, 0); endtask : rd
    task automatic tick(input int n); repeat (n) @(posedge pclk); #1; endtask : tick
    ////////////////////////////////////////////////////////////////
    // One-cycle overcurrent and open load, driven at a rising edge and sampled at the next.
    task automatic oc_pulse();
        @(posedge pclk);
        oc_detect <= 1;
        ol_detect <= 1;
        @(posedge pclk);
        oc_detect <= 0;
        ol_detect <= 0;
        #1;
    endtask : oc_pulse
    // One-cycle soft reset command.
    task automatic sr_pulse();
        @(posedge pclk);
        soft_reset <= 1;
        @(posedge pclk);
        soft_reset <= 0;
    endtask : sr_pulse
    // One-cycle failure trigger.
    task automatic fail_pulse();
        @(posedge pclk);
        failure_event <= 1;
        @(posedge pclk);
        failure_event <= 0;
        #1;
    endtask : fail_pulse
    // Duty extremes, phase following, mode holding and the diagnosis shutdown path.
    task automatic t_switch();
        rd(gpio_pkg::OFF_CTRL);
        chk("ctrl rst", rdv, 0);
        rd(8'h40);
        chk("unmapped", rdv, 0);
        chk("unmapped err", rerr, 1);
        chk("fo level", fo_o, 0);
        w(gpio_pkg::OFF_PWM, 32'hff);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_LS);
        chk("ls", ls, 1);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_HS);
        chk("hs 100", hs, 1);
        w(gpio_pkg::OFF_PWM, 32'h0);
        chk("hs 0", hs, 0);
        w(gpio_pkg::OFF_PWM, 32'h180);
        chk("duty", pwm_duty, 8'h80);
        chk("freq", freq, 1);
        chk("hs ph0", hs, 0);
        @(posedge pclk);
        pwm_phase <= 1;
        tick(1);
        chk("hs ph", hs, 1);
        oc_pulse();
        chk("hs oc", hs, 0);
        rd(gpio_pkg::OFF_CTRL);
        chk("func off", rdv[2:0], gpio_pkg::FN_OFF);
        rd(gpio_pkg::OFF_STATUS);
        chk("ol oc", rdv[1:0], 2'h3);
        tick(2500);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_HS);
        chk("reen", hs, 1);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_STOP;
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_LS);
        chk("stop hs", hs, 1);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_RESTART;
        tick(2);
        chk("hs rst", hs, 0);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_NORMAL;
        tick(1);
        chk("stay off", hs, 0);
    endtask : t_switch
    // Cyclic sense, wake input, lock and soft reset.
    task automatic t_cfg();
        w(gpio_pkg::OFF_STATUS, 32'h3);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_CS);
        @(posedge pclk);
        timer_start <= 1;
        timer_on <= 1;
        #1 chk("learn", learning_start, 1);
        chk("cs on", hs, 1);
        oc_pulse();
        chk("cs oc", hs, 0);
        rd(gpio_pkg::OFF_STATUS);
        chk("cs diag", rdv[1:0], 2'h2);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_WAKE);
        chk("no learn", learning_start, 0);
        chk("no timer hs", hs, 0);
        @(posedge pclk);
        timer_start <= 0;
        timer_on <= 0;
        pin_level <= 1;
        #1 chk("wake req", wake_request, 1);
        tick(1);
        chk("wake ref", wake_request, 0);
        rd(gpio_pkg::OFF_STATUS);
        chk("wake flag", rdv[2], 1);
        chk("lvl", rdv[5], 1);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_RESTART;
        rd(gpio_pkg::OFF_STATUS);
        chk("lvl rst", rdv[5], 0);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_NORMAL;
        w(gpio_pkg::OFF_TIMER, 5);
        chk("tmr", timer_on_time, 5);
        sr_pulse();
        rd(gpio_pkg::OFF_CTRL);
        chk("sr func", rdv[2:0], 0);
        chk("sr tmr", timer_on_time, 0);
        chk("sr duty", pwm_duty, 0);
        chk("sr freq", freq, 0);
        w(gpio_pkg::OFF_CTRL, 32'hc);
        w(gpio_pkg::OFF_CTRL, 32'hd);
        rd(gpio_pkg::OFF_CTRL);
        chk("lock", rdv[2:0], gpio_pkg::FN_OFF);
        sr_pulse();
        rd(gpio_pkg::OFF_CTRL);
        chk("sr lock", rdv[2:0], gpio_pkg::FN_OFF);
        w(gpio_pkg::OFF_CTRL, gpio_pkg::FN_OFF);
    endtask : t_cfg
    // Measurement interlock, then failure handling.
    task automatic t_meas();
        w(gpio_pkg::OFF_CTRL, 32'h24);
        w(gpio_pkg::OFF_PULL, 1);
        chk("pull", wake_pull, 0);
        w(gpio_pkg::OFF_CTRL, 32'h27);
        rd(gpio_pkg::OFF_CTRL);
        chk("blk", rdv[2:0], gpio_pkg::FN_OFF);
        rd(gpio_pkg::OFF_STATUS);
        chk("cmdf", rdv[4], 1);
        @(posedge pclk);
        sleep_request <= 1;
        wake_only_source <= 1;
        #1 chk("rsreq", restart_request, 1);
        @(posedge pclk);
        sleep_request <= 0;
        w(gpio_pkg::OFF_CTRL, 4);
        chk("pull on", wake_pull, 1);
        rd(gpio_pkg::OFF_STATUS);
        chk("sleep fail", rdv[3], 1);
        w(gpio_pkg::OFF_STATUS, 32'h1f);
        w(gpio_pkg::OFF_CTRL, 0);
        w(gpio_pkg::OFF_CTRL, 32'h20);
        rd(gpio_pkg::OFF_CTRL);
        chk("meas ref", rdv[5], 0);
        rd(gpio_pkg::OFF_STATUS);
        chk("cmdf2", rdv[4], 1);
        w(gpio_pkg::OFF_CTRL, 32'h14);
        fail_pulse();
        chk("fo off", fo_oe, 0);
        w(gpio_pkg::OFF_STATUS, 32'h8);
        rd(gpio_pkg::OFF_STATUS);
        chk("fclr", rdv[3], 0);
        w(gpio_pkg::OFF_CTRL, 0);
        fail_pulse();
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_RESTART;
        tick(2);
        chk("fo rst", fo_oe, 1);
        @(posedge pclk);
        sbc_mode <= gpio_pkg::MD_NORMAL;
        tick(1);
        chk("fo keep", fo_oe, 1);
    endtask : t_meas
    initial begin
        {presetn, psel, penable, pwrite, soft_reset, failure_event, failure_present, pwm_phase} = 0;
        {timer_on, timer_start, oc_detect, ol_detect, pin_level, sleep_request, wake_only_source} = 0;
        paddr = 0; pwdata = 0; sbc_mode = gpio_pkg::MD_NORMAL;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_switch();
        t_cfg();
        t_meas();
        end_of_test();
    end
endmodule : failout_gpio_switch_control_tb_top
